/* File: ocu_pkg.sv */
// package for the output compare unit: register map, fields, mode codes, state
package ocu_pkg;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_MATCH   = 8'h04;
  localparam logic [7:0] OFS_CONFIG  = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0c;
  localparam logic [7:0] OFS_MASK    = 8'h10;
  localparam int CTRL_W = 6;
  localparam int MODE_W = 4;
  localparam int CFG_SEL_BIT = 0;
  localparam int CFG_ADC_BIT = 1;
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_PIN_BIT  = 1;
  localparam logic [MODE_W-1:0] MODE_OFF    = 4'h0;
  localparam logic [MODE_W-1:0] MODE_TOGGLE = 4'h2;
  localparam logic [MODE_W-1:0] MODE_HIGH   = 4'h8;
  localparam logic [MODE_W-1:0] MODE_LOW    = 4'h9;
  localparam logic [MODE_W-1:0] MODE_SWINT  = 4'ha;
  localparam logic [MODE_W-1:0] MODE_SEVT   = 4'hb;
  localparam logic [CTRL_W-1:0] CTRL_RESET  = 6'h00;
  localparam logic [15:0]       MATCH_RESET = 16'h0000;
  localparam logic [31:0]       ZERO_WORD   = 32'h0000_0000;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [15:0]       match_value;
    logic              timebase_sel;
    logic              adc_trig_en;
    logic              flag;
    logic              irq_enable;
    logic              latch;
    logic              pin;
    logic              match_prev;
    logic              first_rst;
    logic              third_rst;
    logic              adc_start;
    logic              irq;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } ocu_state_t;
endpackage : ocu_pkg

/* File: ocu_top.sv */
// output compare unit: apb registers, 16-bit match, pin action, event trigger
// Behaviour
// - compare full match value with selected timer
// - match drives, clears, toggles or leaves pin
// - flag set with pin action, same cycle
// - zero control forces compare latch low
// - software interrupt mode leaves pin untouched
// - interrupt reaches cpu only when enabled
// - event trigger only in trigger mode
// - event trigger resets selected timebase timer
// - second module trigger starts enabled converter
// - 1000 high, 1001 low, 0010 toggle
// - mode 0000 disables and resets state
`timescale 1ns/100ps
module ocu_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  // apb slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // timebases and port
  input  wire logic [15:0]       FIRST_COUNT,
  input  wire logic [15:0]       THIRD_COUNT,
  input  wire logic              IO_LATCH,
  input  wire logic              ADC_ENABLED,
  // outputs
  output logic                   PIN_OUT,
  output logic                   FIRST_TIMER_RESET,
  output logic                   THIRD_TIMER_RESET,
  output logic                   ADC_START,
  output logic                   IRQ
);
  ocu_pkg::ocu_state_t s_reg;
  ocu_pkg::ocu_state_t s_next;

  function automatic logic is_compare(input logic [ocu_pkg::MODE_W-1:0] m);
    is_compare = (m == ocu_pkg::MODE_TOGGLE) || (m == ocu_pkg::MODE_HIGH) ||
                 (m == ocu_pkg::MODE_LOW) || (m == ocu_pkg::MODE_SWINT) ||
                 (m == ocu_pkg::MODE_SEVT);
  endfunction : is_compare

  function automatic logic drives_pin(input logic [ocu_pkg::MODE_W-1:0] m);
    drives_pin = (m == ocu_pkg::MODE_TOGGLE) || (m == ocu_pkg::MODE_HIGH) ||
                 (m == ocu_pkg::MODE_LOW);
  endfunction : drives_pin

  logic [ocu_pkg::MODE_W-1:0] mode;
  logic [15:0]                sel_count;
  logic                       equal;
  logic                       match_evt;
  logic                       access;
  logic                       wr_done;
  logic                       rd_done;
  logic [7:0]                 addr;
  logic                       mapped;

  assign mode      = s_reg.ctrl[ocu_pkg::MODE_W-1:0];
  assign sel_count = s_reg.timebase_sel ? THIRD_COUNT : FIRST_COUNT;
  assign equal     = (sel_count == s_reg.match_value);
  // edge of equality, so a stalled timer cannot retrigger the toggle
  assign match_evt = is_compare(mode) && equal && !s_reg.match_prev;
  assign access    = PSEL && PENABLE;
  assign wr_done   = access && s_reg.pready && PWRITE;
  assign rd_done   = access && s_reg.pready && !PWRITE;
  assign addr      = 8'(PADDR);
  assign mapped    = (addr == ocu_pkg::OFS_CONTROL) || (addr == ocu_pkg::OFS_MATCH) ||
                     (addr == ocu_pkg::OFS_CONFIG) || (addr == ocu_pkg::OFS_STATUS) ||
                     (addr == ocu_pkg::OFS_MASK);

  always_comb begin
    s_next = s_reg;
    s_next.first_rst = 1'b0;
    s_next.third_rst = 1'b0;
    s_next.adc_start = 1'b0;
    s_next.match_prev = equal;
    // one wait state: ready rises in the second access cycle
    s_next.pready = access && !s_reg.pready;
    s_next.pslverr = access && !s_reg.pready && !mapped;
    // register writes
    if (wr_done && mapped) begin
      unique case (addr)
        ocu_pkg::OFS_CONTROL: begin
          s_next.ctrl = PWDATA[ocu_pkg::CTRL_W-1:0];
          if (PWDATA[ocu_pkg::MODE_W-1:0] == ocu_pkg::MODE_HIGH) begin
            s_next.latch = 1'b0;
          end
          if (PWDATA[ocu_pkg::MODE_W-1:0] == ocu_pkg::MODE_LOW) begin
            s_next.latch = 1'b1;
          end
        end
        ocu_pkg::OFS_MATCH: s_next.match_value = PWDATA[15:0];
        ocu_pkg::OFS_CONFIG: begin
          s_next.timebase_sel = PWDATA[ocu_pkg::CFG_SEL_BIT];
          s_next.adc_trig_en  = PWDATA[ocu_pkg::CFG_ADC_BIT];
        end
        ocu_pkg::OFS_MASK: s_next.irq_enable = PWDATA[ocu_pkg::STAT_FLAG_BIT];
        default: s_next.ctrl = s_reg.ctrl;
      endcase
    end
    // read data prepared in the cycle before ready is seen
    s_next.prdata = ocu_pkg::ZERO_WORD;
    if (access && !s_reg.pready && !PWRITE) begin
      unique case (addr)
        ocu_pkg::OFS_CONTROL: s_next.prdata[ocu_pkg::CTRL_W-1:0] = s_reg.ctrl;
        ocu_pkg::OFS_MATCH:   s_next.prdata[15:0] = s_reg.match_value;
        ocu_pkg::OFS_CONFIG: begin
          s_next.prdata[ocu_pkg::CFG_SEL_BIT] = s_reg.timebase_sel;
          s_next.prdata[ocu_pkg::CFG_ADC_BIT] = s_reg.adc_trig_en;
        end
        ocu_pkg::OFS_STATUS: begin
          s_next.prdata[ocu_pkg::STAT_FLAG_BIT] = s_reg.flag;
          s_next.prdata[ocu_pkg::STAT_PIN_BIT]  = s_reg.pin;
        end
        ocu_pkg::OFS_MASK: s_next.prdata[ocu_pkg::STAT_FLAG_BIT] = s_reg.irq_enable;
        default: s_next.prdata = ocu_pkg::ZERO_WORD;
      endcase
    end
    // reading status clears the flag; a match in that cycle wins
    if (rd_done && addr == ocu_pkg::OFS_STATUS) begin
      s_next.flag = 1'b0;
    end
    if (match_evt) begin
      s_next.flag = 1'b1;
      unique case (mode)
        ocu_pkg::MODE_HIGH:   s_next.latch = 1'b1;
        ocu_pkg::MODE_LOW:    s_next.latch = 1'b0;
        ocu_pkg::MODE_TOGGLE: s_next.latch = !s_reg.latch;
        ocu_pkg::MODE_SEVT: begin
          s_next.first_rst = !s_reg.timebase_sel;
          s_next.third_rst = s_reg.timebase_sel;
          s_next.adc_start = s_reg.adc_trig_en && ADC_ENABLED;
        end
        default: s_next.latch = s_reg.latch;
      endcase
    end
    // disabled: latch held low and any match history forgotten
    if (s_next.ctrl[ocu_pkg::MODE_W-1:0] == ocu_pkg::MODE_OFF) begin
      s_next.latch = 1'b0;
      s_next.match_prev = 1'b0;
    end
    // pin follows the port latch unless a driving compare mode owns it
    s_next.pin = drives_pin(s_next.ctrl[ocu_pkg::MODE_W-1:0]) ? s_next.latch : IO_LATCH;
    s_next.irq = s_next.flag && s_next.irq_enable;
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign PRDATA            = s_reg.prdata;
  assign PREADY            = s_reg.pready;
  assign PSLVERR           = s_reg.pslverr;
  assign PIN_OUT           = s_reg.pin;
  assign FIRST_TIMER_RESET = s_reg.first_rst;
  assign THIRD_TIMER_RESET = s_reg.third_rst;
  assign ADC_START         = s_reg.adc_start;
  assign IRQ               = s_reg.irq;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_match_in(logic [ocu_pkg::MODE_W-1:0] m);
    match_evt && mode == m && !wr_done;
  endsequence

  sequence s_sevt_first;
    s_match_in(ocu_pkg::MODE_SEVT) and !s_reg.timebase_sel;
  endsequence

  property p_match_cause;
    match_evt |-> sel_count == s_reg.match_value && !s_reg.match_prev;
  endproperty
  a_match_cause: assert property (p_match_cause) else $error("match without equal count");

  property p_flag_set;
    match_evt |=> s_reg.flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on match");

  property p_drive_high;
    s_match_in(ocu_pkg::MODE_HIGH) |=> s_reg.latch && PIN_OUT;
  endproperty
  a_drive_high: assert property (p_drive_high) else $error("pin not driven high");

  property p_drive_low;
    s_match_in(ocu_pkg::MODE_LOW) |=> !s_reg.latch && !PIN_OUT;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("pin not driven low");

  property p_toggle;
    s_match_in(ocu_pkg::MODE_TOGGLE) |=> s_reg.latch != $past(s_reg.latch);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin not toggled");

  property p_swint;
    s_match_in(ocu_pkg::MODE_SWINT) |=> s_reg.latch == $past(s_reg.latch) && PIN_OUT == $past(IO_LATCH);
  endproperty
  a_swint: assert property (p_swint) else $error("pin touched in interrupt mode");

  property p_irq_gate;
    IRQ == (s_reg.flag && s_reg.irq_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not gated by enable");

  property p_trig_mode;
    (FIRST_TIMER_RESET || THIRD_TIMER_RESET) |-> $past(mode) == ocu_pkg::MODE_SEVT;
  endproperty
  a_trig_mode: assert property (p_trig_mode) else $error("trigger outside trigger mode");

  property p_trig_first;
    s_sevt_first |=> FIRST_TIMER_RESET && !THIRD_TIMER_RESET ##1 !FIRST_TIMER_RESET;
  endproperty
  a_trig_first: assert property (p_trig_first) else $error("wrong timer reset");

  property p_adc;
    ADC_START |-> $past(s_reg.adc_trig_en) && $past(ADC_ENABLED) && $past(match_evt);
  endproperty
  a_adc: assert property (p_adc) else $error("conversion started without cause");

  property p_off_low;
    mode == ocu_pkg::MODE_OFF |-> !s_reg.latch;
  endproperty
  a_off_low: assert property (p_off_low) else $error("latch not low when off");

  property p_flag_sticks;
    s_reg.flag && !(rd_done && addr == ocu_pkg::OFS_STATUS) |=> s_reg.flag;
  endproperty
  a_flag_sticks: assert property (p_flag_sticks) else $error("flag dropped without read");

  sequence s_sevt_third;
    s_match_in(ocu_pkg::MODE_SEVT) and s_reg.timebase_sel;
  endsequence

  // control write that no match in the same cycle overrides
  sequence s_ctrl_write(logic [ocu_pkg::MODE_W-1:0] m);
    wr_done && addr == ocu_pkg::OFS_CONTROL && PWDATA[ocu_pkg::MODE_W-1:0] == m && !match_evt;
  endsequence

  property p_trig_third;
    s_sevt_third |=> THIRD_TIMER_RESET && !FIRST_TIMER_RESET ##1 !THIRD_TIMER_RESET;
  endproperty
  a_trig_third: assert property (p_trig_third) else $error("third timer not reset alone");

  property p_no_trig_other;
    match_evt && mode != ocu_pkg::MODE_SEVT |=> !FIRST_TIMER_RESET && !THIRD_TIMER_RESET && !ADC_START;
  endproperty
  a_no_trig_other: assert property (p_no_trig_other) else $error("trigger from non trigger mode");

  property p_off_pin;
    mode == ocu_pkg::MODE_OFF && !wr_done |=> PIN_OUT == $past(IO_LATCH);
  endproperty
  a_off_pin: assert property (p_off_pin) else $error("port latch lost while off");

  property p_off_state;
    mode == ocu_pkg::MODE_OFF && !wr_done |=> !s_reg.match_prev && !s_reg.latch;
  endproperty
  a_off_state: assert property (p_off_state) else $error("state kept while off");

  property p_stall_once;
    match_evt ##1 equal |-> !match_evt;
  endproperty
  a_stall_once: assert property (p_stall_once) else $error("held equality acted twice");

  property p_swint_flag;
    s_match_in(ocu_pkg::MODE_SWINT) |=> s_reg.flag && IRQ == s_reg.irq_enable;
  endproperty
  a_swint_flag: assert property (p_swint_flag) else $error("interrupt mode match lost");

  property p_adc_go;
    s_match_in(ocu_pkg::MODE_SEVT) and (s_reg.adc_trig_en && ADC_ENABLED) |=> ADC_START;
  endproperty
  a_adc_go: assert property (p_adc_go) else $error("conversion not started");

  property p_adc_once;
    ADC_START |=> !ADC_START;
  endproperty
  a_adc_once: assert property (p_adc_once) else $error("conversion start too long");

  property p_zero_ctrl;
    s_ctrl_write(ocu_pkg::MODE_OFF) |=> !s_reg.latch && mode == ocu_pkg::MODE_OFF;
  endproperty
  a_zero_ctrl: assert property (p_zero_ctrl) else $error("zero control left latch set");

  property p_init_low;
    s_ctrl_write(ocu_pkg::MODE_HIGH) |=> !s_reg.latch && !PIN_OUT;
  endproperty
  a_init_low: assert property (p_init_low) else $error("pin not initialised low");

  property p_init_high;
    s_ctrl_write(ocu_pkg::MODE_LOW) |=> s_reg.latch && PIN_OUT;
  endproperty
  a_init_high: assert property (p_init_high) else $error("pin not initialised high");
endmodule : ocu_top

/* File: ocu_partner.sv */
// timebase timer model seen by the output compare unit
`timescale 1ns/100ps
module ocu_partner (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // bench control
  input  wire logic        clear,
  input  wire logic [1:0]  run,
  // triggers from the unit
  input  wire logic        first_rst,
  input  wire logic        third_rst,
  // counts
  output logic      [15:0] first_count,
  output logic      [15:0] third_count
);
  // counts on the unit clock only: no asynchronous counter mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      first_count <= 16'h0000;
      third_count <= 16'h0000;
    end else begin
      if (clear || first_rst) first_count <= 16'h0000;
      else if (run[0]) first_count <= first_count + 16'h0001;
      if (clear || third_rst) third_count <= 16'h0000;
      else if (run[1]) third_count <= third_count + 16'h0001;
    end
  end
endmodule : ocu_partner

/* File: output_compare_unit_tb.sv */
// self-checking bench for the output compare unit
`timescale 1ns/100ps
module output_compare_unit_tb;
  logic        ref_clk, rst, psel, penable, pwrite, io_latch, adc_enabled, clear, er;
  logic [1:0]  run;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] first_count, third_count;
  logic        pready, pslverr, pin_out, first_timer_reset, third_timer_reset, adc_start, irq;
  int          fails, n_tests, n, n_pulse;
  logic [3:0]  modes [3];
  logic        pin_init [3];

  ocu_top #(.ADDR_W(8)) dut (.REF_CLK(ref_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .FIRST_COUNT(first_count), .THIRD_COUNT(third_count),
    .IO_LATCH(io_latch), .ADC_ENABLED(adc_enabled), .PIN_OUT(pin_out),
    .FIRST_TIMER_RESET(first_timer_reset), .THIRD_TIMER_RESET(third_timer_reset),
    .ADC_START(adc_start), .IRQ(irq));
  ocu_partner u_timer (.clk(ref_clk), .rst(rst), .clear(clear), .run(run),
    .first_rst(first_timer_reset), .third_rst(third_timer_reset),
    .first_count(first_count), .third_count(third_count));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // every timer reset pulse is counted here, whatever the mode
  always @(posedge ref_clk) if (first_timer_reset === 1'b1 || third_timer_reset === 1'b1) n_pulse++;

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // leading edge keeps one idle cycle between transfers
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no assumed wait: only the watchdog ends a hung transfer
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic err);
    xfer(1'b0, a, ocu_pkg::ZERO_WORD);
    chk("prdata", exp, rd);
    chk("pslverr", {31'h0, err}, {31'h0, er});
  endtask : rd_chk

  // bounded wait for the interrupt or the third timer reset
  task automatic wait_for(input bit on_reset);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while ((on_reset ? third_timer_reset : irq) !== 1'b1 && n < 400);
    if (n >= 400) fails++;
  endtask : wait_for

  // stop and clear the timers, then program mode from off
  task automatic setup(input logic [3:0] m, input logic [15:0] mv);
    run <= 2'b00;
    clear <= 1'b1;
    xfer(1'b1, ocu_pkg::OFS_CONTROL, ocu_pkg::ZERO_WORD);
    clear <= 1'b0;
    xfer(1'b1, ocu_pkg::OFS_MATCH, {16'h0, mv});
    xfer(1'b1, ocu_pkg::OFS_CONTROL, {28'h0, m});
    xfer(1'b0, ocu_pkg::OFS_STATUS, ocu_pkg::ZERO_WORD);
  endtask : setup

  initial begin
    {rst, psel, penable, pwrite, io_latch, adc_enabled, clear} = 7'h40;
    {run, paddr, pwdata, fails, n_tests, n_pulse} = '0;
    modes = '{ocu_pkg::MODE_LOW, ocu_pkg::MODE_HIGH, ocu_pkg::MODE_TOGGLE};
    pin_init = '{1'b1, 1'b0, 1'b0};
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) rd_chk(8'(4 * i), ocu_pkg::ZERO_WORD, 1'b0);
    xfer(1'b1, 8'h14, 32'hffff_ffff);
    chk("unmapped write err", 32'h1, {31'h0, er});
    rd_chk(8'h14, ocu_pkg::ZERO_WORD, 1'b1);
    xfer(1'b1, ocu_pkg::OFS_CONTROL, 32'hffff_ff30);
    rd_chk(ocu_pkg::OFS_CONTROL, 32'h0000_0030, 1'b0);
    xfer(1'b1, ocu_pkg::OFS_MATCH, 32'hffff_ffff);
    rd_chk(ocu_pkg::OFS_MATCH, 32'h0000_ffff, 1'b0);
    xfer(1'b1, ocu_pkg::OFS_MASK, 32'h1);
    // 0x0110 also passes 0x0010 first, so a low-byte compare fires early
    for (int i = 0; i < 3; i++) begin
      setup(modes[i], 16'h0110);
      chk("pin init", {31'h0, pin_init[i]}, {31'h0, pin_out});
      run <= 2'b01;
      wait_for(1'b0);
      chk("match delay", 32'd274, 32'(n));
      chk("pin on match", {31'h0, ~pin_init[i]}, {31'h0, pin_out});
      repeat (6) @(posedge ref_clk);
      chk("irq held", 32'h1, {31'h0, irq});
      rd_chk(ocu_pkg::OFS_STATUS, {30'h0, ~pin_init[i], 1'b1}, 1'b0);
      rd_chk(ocu_pkg::OFS_STATUS, {30'h0, ~pin_init[i], 1'b0}, 1'b0);
      chk("irq cleared", 32'h0, {31'h0, irq});
    end
    io_latch <= 1'b1;
    xfer(1'b1, ocu_pkg::OFS_MASK, ocu_pkg::ZERO_WORD);
    setup(ocu_pkg::MODE_SWINT, 16'h0010);
    run <= 2'b01;
    repeat (24) @(posedge ref_clk);
    chk("masked irq", 32'h0, {31'h0, irq});
    chk("pin untouched", 32'h1, {31'h0, pin_out});
    rd_chk(ocu_pkg::OFS_STATUS, 32'h3, 1'b0);
    chk("no trigger", 32'h0, 32'(n_pulse));
    xfer(1'b1, ocu_pkg::OFS_MASK, 32'h1);
    xfer(1'b1, ocu_pkg::OFS_CONFIG, 32'h3);
    adc_enabled <= 1'b1;
    setup(ocu_pkg::MODE_SEVT, 16'h0010);
    run <= 2'b10;
    wait_for(1'b1);
    chk("third reset delay", 32'd18, 32'(n));
    chk("adc start", 32'h1, {31'h0, adc_start});
    chk("first not reset", 32'h0, {31'h0, first_timer_reset});
    chk("irq on trigger", 32'h1, {31'h0, irq});
    adc_enabled <= 1'b0;
    wait_for(1'b1);
    chk("trigger period", 32'd18, 32'(n));
    chk("adc disabled", 32'h0, {31'h0, adc_start});
    // trigger mode on the first timer: only that timer is reset
    xfer(1'b1, ocu_pkg::OFS_CONFIG, ocu_pkg::ZERO_WORD);
    setup(ocu_pkg::MODE_SEVT, 16'h0010);
    run <= 2'b01;
    wait_for(1'b0);
    chk("first reset delay", 32'd18, 32'(n));
    chk("first reset", 32'h1, {31'h0, first_timer_reset});
    chk("third not reset", 32'h0, {31'h0, third_timer_reset});
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end
endmodule : output_compare_unit_tb
